/* File: core/dram_mode_pkg.sv */
// constants for the memory init and mode setup block
`default_nettype none
package dram_mode_pkg;
    localparam int unsigned ADDR_W          = 21;
    localparam int unsigned MODE_W          = 18;
    localparam int unsigned LAT_W           = 4;
    // mode word field positions
    localparam int unsigned CFG_LSB         = 0;
    localparam int unsigned BL_LSB          = 3;
    localparam int unsigned MUX_BIT         = 5;
    localparam int unsigned DLL_BIT         = 7;
    localparam int unsigned IMP_BIT         = 8;
    localparam int unsigned ODT_BIT         = 9;
    localparam int unsigned ZERO_LSB        = 10;
    // multiplexed-mode configuration bits in the second part
    localparam int unsigned MUX_CFG_LO      = 3;
    localparam int unsigned MUX_CFG_HI      = 4;
    localparam logic [MODE_W-1:0] MODE_RESET = 18'h00000;
    // burst length codes
    localparam logic [1:0] BL_CODE_2        = 2'h0;
    localparam logic [1:0] BL_CODE_4        = 2'h1;
    localparam logic [1:0] BL_CODE_8        = 2'h2;
    localparam logic [3:0] BL_2             = 4'h2;
    localparam logic [3:0] BL_4             = 4'h4;
    localparam logic [3:0] BL_8             = 4'h8;
    // configuration codes
    localparam logic [2:0] CFG_2            = 3'h2;
    localparam logic [2:0] CFG_3            = 3'h3;
    localparam logic [2:0] CFG_4            = 3'h4;
    localparam logic [2:0] CFG_5            = 3'h5;
    localparam logic [2:0] CFG_RSV_A        = 3'h6;
    localparam logic [2:0] CFG_RSV_B        = 3'h7;
    // device data width: 0 = x9, 1 = x18, 2 = x36
    localparam logic [1:0] DATA_WIDTH_SEL   = 2'h1;
    localparam logic [4:0] TOP_BIT_X9_BL2   = 5'h14;
    // timing in link clock cycles
    localparam int unsigned MODE_WRITE_RECOVERY_TIME = 6;
    localparam int unsigned MIN_INIT_MRS    = 3;
    localparam int unsigned INIT_NOP_COUNT  = 1024;
    localparam int unsigned DLL_LOCK_CYCLES = 1024;
    localparam int unsigned NUM_BANKS       = 8;
    localparam logic [NUM_BANKS-1:0] ALL_BANKS = 8'hff;

    typedef enum logic [4:0] {
        ST_WAIT_MRS = 5'b00001,
        ST_MRS_RUN  = 5'b00010,
        ST_RECOVER  = 5'b00100,
        ST_REFRESH  = 5'b01000,
        ST_READY    = 5'b10000
    } init_state_t;
endpackage
`default_nettype wire

/* File: core/dram_mode_setup.sv */
// init sequence tracking and mode register of the memory device
`timescale 1ns/100ps
`default_nettype none
module dram_mode_setup
    import dram_mode_pkg::*;
(
    input  wire logic              REF_CLK_I,
    input  wire logic              RST_I,
    input  wire logic              CK_I,
    input  wire logic              CS_N_I,
    input  wire logic              WE_N_I,
    input  wire logic              REF_N_I,
    input  wire logic [2:0]        BANK_SELECT_BITS_I,
    input  wire logic [ADDR_W-1:0] ADDR_I,
    output logic [MODE_W-1:0]      MODE_WORD_O,
    output logic [LAT_W-1:0]       ROW_CYCLE_O,
    output logic [LAT_W-1:0]       READ_LAT_O,
    output logic [LAT_W-1:0]       WRITE_LAT_O,
    output logic [3:0]             BURST_LEN_O,
    output logic [4:0]             ADDR_TOP_BIT_O,
    output logic                   MUX_MODE_O,
    output logic                   DLL_ON_O,
    output logic                   DLL_LOCKED_O,
    output logic                   IMPEDANCE_EXT_O,
    output logic                   ODT_EN_O,
    output logic                   INIT_DONE_O,
    output logic                   CFG_RESERVED_O,
    output logic                   TIMING_ERR_O,
    output logic                   DATA_STALE_O
);
    // pins: two flops each, ck edge found on the second stage
    logic [ADDR_W+5:0] pin_s1_ff, pin_s2_ff;
    logic              ck_d_ff;
    always_ff @(posedge REF_CLK_I) begin
        pin_s1_ff <= {CK_I, CS_N_I, WE_N_I, REF_N_I, BANK_SELECT_BITS_I[0], ADDR_I, 1'b0};
        pin_s2_ff <= pin_s1_ff;
        ck_d_ff   <= pin_s2_ff[ADDR_W+5];
    end
    wire logic              ck_s   = pin_s2_ff[ADDR_W+5];
    wire logic              cs_n   = pin_s2_ff[ADDR_W+4];
    wire logic              we_n   = pin_s2_ff[ADDR_W+3];
    wire logic              ref_n  = pin_s2_ff[ADDR_W+2];
    wire logic [ADDR_W-1:0] addr   = pin_s2_ff[ADDR_W:1];
    wire logic              edge_p = ck_s & ~ck_d_ff;

    // bank address is sampled through its own synchroniser
    logic [2:0] bank_s1_ff, bank_s2_ff;
    always_ff @(posedge REF_CLK_I) begin
        bank_s1_ff <= BANK_SELECT_BITS_I;
        bank_s2_ff <= bank_s1_ff;
    end

    wire logic is_mrs  = edge_p & ~cs_n & ~we_n & ~ref_n;
    wire logic is_bank_refresh_cmd = edge_p & ~cs_n & we_n & ~ref_n;
    wire logic is_nop  = edge_p & cs_n;
    wire logic is_cmd  = edge_p & ~cs_n;

    function automatic logic [7:0] cfg_decode(input logic [2:0] code);
        case (code)
            CFG_2:   cfg_decode = {4'h6, 4'h6};
            CFG_3:   cfg_decode = {4'h8, 4'h8};
            CFG_4:   cfg_decode = {4'h3, 4'h3};
            CFG_5:   cfg_decode = {4'h5, 4'h5};
            default: cfg_decode = {4'h4, 4'h4};
        endcase
    endfunction

    function automatic logic [3:0] bl_decode(input logic [1:0] code);
        if (code == BL_CODE_8)
            bl_decode = BL_8;
        else if (code == BL_CODE_4)
            bl_decode = BL_4;
        else
            bl_decode = BL_2;
    endfunction

    // top used address bit drops one per burst step and width step
    function automatic logic [4:0] top_bit(input logic [3:0] bl);
        logic [4:0] step;
        step = (bl == BL_8) ? 5'h2 : (bl == BL_4) ? 5'h1 : 5'h0;
        top_bit = TOP_BIT_X9_BL2 - step - {3'h0, DATA_WIDTH_SEL};
    endfunction

    // multiplexed mode write: first part held until second part arrives
    logic              mux_mode_ff;
    logic              second_pend_ff;
    logic [ADDR_W-1:0] first_part_ff;
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            second_pend_ff <= 1'b0;
            first_part_ff  <= '0;
        end else if (edge_p) begin
            second_pend_ff <= is_mrs & mux_mode_ff;
            if (is_mrs)
                first_part_ff <= addr;
        end
    end

    // assembled word and moment it takes effect
    logic              apply;
    logic [MODE_W-1:0] word;
    logic [2:0]        code;
    always_comb begin
        word = addr[MODE_W-1:0];
        code = addr[CFG_LSB+2:CFG_LSB];
        apply = 1'b0;
        if (mux_mode_ff) begin
            apply = edge_p & second_pend_ff & first_part_ff[MUX_BIT];
            word  = first_part_ff[MODE_W-1:0];
            word[DLL_BIT] = addr[DLL_BIT];
            code  = {addr[MUX_CFG_HI], addr[MUX_CFG_LO], first_part_ff[CFG_LSB]};
            word[CFG_LSB+2:CFG_LSB] = code;
        end else begin
            apply = is_mrs;
        end
    end
    wire logic reserved = (code == CFG_RSV_A) | (code == CFG_RSV_B);

    // settings; reserved codes keep the previous timing
    logic [MODE_W-1:0] mode_ff;
    logic [LAT_W-1:0]  trc_ff, trl_ff;
    logic [3:0]        bl_ff;
    logic              rsv_ff, stale_ff;
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            mode_ff     <= MODE_RESET;
            mux_mode_ff <= 1'b0;
            trc_ff      <= 4'h4;
            trl_ff      <= 4'h4;
            bl_ff       <= BL_2;
            rsv_ff      <= 1'b0;
            stale_ff    <= 1'b0;
        end else if (apply) begin
            mode_ff <= word;
            rsv_ff  <= reserved;
            if (!reserved)
                {trc_ff, trl_ff} <= cfg_decode(code);
            bl_ff <= bl_decode(word[BL_LSB+1:BL_LSB]);
            if (bl_decode(word[BL_LSB+1:BL_LSB]) != bl_ff)
                stale_ff <= 1'b1;
            if (!mux_mode_ff && word[MUX_BIT])
                mux_mode_ff <= 1'b1;
        end
    end

    // recovery interval after every mode write
    init_state_t state_ff;
    logic [2:0] rec_ff;
    logic       err_ff;
    wire logic  in_run = is_mrs & ((state_ff == ST_WAIT_MRS) | (state_ff == ST_MRS_RUN));
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            rec_ff <= 3'h0;
            err_ff <= 1'b0;
        end else if (edge_p) begin
            if (is_mrs || second_pend_ff)
                rec_ff <= 3'(MODE_WRITE_RECOVERY_TIME - 1);
            else if (rec_ff != 3'h0)
                rec_ff <= rec_ff - 3'h1;
            if (is_cmd && rec_ff != 3'h0 && !in_run && !second_pend_ff)
                err_ff <= 1'b1;
        end
    end

    // init sequence
    logic [1:0]  run_ff;
    logic [10:0] nop_ff;
    logic [NUM_BANKS-1:0] banks_ff;
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            state_ff <= ST_WAIT_MRS;
            run_ff   <= 2'h0;
            nop_ff   <= 11'h000;
            banks_ff <= '0;
        end else if (edge_p) begin
            case (state_ff)
                ST_WAIT_MRS: begin
                    if (is_mrs) begin
                        run_ff   <= 2'h1;
                        state_ff <= ST_MRS_RUN;
                    end
                end
                ST_MRS_RUN: begin
                    if (is_mrs) begin
                        if (run_ff != 2'(MIN_INIT_MRS))
                            run_ff <= run_ff + 2'h1;
                    end else if (run_ff == 2'(MIN_INIT_MRS)) begin
                        state_ff <= ST_RECOVER;
                    end else begin
                        state_ff <= ST_WAIT_MRS;
                    end
                end
                ST_RECOVER: begin
                    if (rec_ff == 3'h1 || rec_ff == 3'h0)
                        state_ff <= ST_REFRESH;
                end
                ST_REFRESH: begin
                    if (is_bank_refresh_cmd)
                        banks_ff[bank_s2_ff] <= 1'b1;
                    if (is_nop && nop_ff != 11'(INIT_NOP_COUNT))
                        nop_ff <= nop_ff + 11'h001;
                    if (banks_ff == ALL_BANKS && nop_ff == 11'(INIT_NOP_COUNT))
                        state_ff <= ST_READY;
                end
                ST_READY: state_ff <= ST_READY;
                default:  state_ff <= ST_WAIT_MRS;
            endcase
        end
    end

    // dll lock wait after enabling; low value holds the dll off
    logic [10:0] lock_ff;
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I || !mode_ff[DLL_BIT])
            lock_ff <= 11'h000;
        else if (edge_p && lock_ff != 11'(DLL_LOCK_CYCLES))
            lock_ff <= lock_ff + 11'h001;
    end

    assign MODE_WORD_O     = mode_ff;
    assign ROW_CYCLE_O     = trc_ff;
    assign READ_LAT_O      = trl_ff + {3'h0, mux_mode_ff};
    assign WRITE_LAT_O     = trl_ff + {3'h0, mux_mode_ff} + 4'h1;
    assign BURST_LEN_O     = bl_ff;
    assign ADDR_TOP_BIT_O  = top_bit(bl_ff);
    assign MUX_MODE_O      = mux_mode_ff;
    assign DLL_ON_O        = mode_ff[DLL_BIT];
    assign DLL_LOCKED_O    = mode_ff[DLL_BIT] && (lock_ff == 11'(DLL_LOCK_CYCLES));
    assign IMPEDANCE_EXT_O = mode_ff[IMP_BIT];
    assign ODT_EN_O        = mode_ff[ODT_BIT];
    assign INIT_DONE_O     = state_ff == ST_READY;
    assign CFG_RESERVED_O  = rsv_ff;
    assign TIMING_ERR_O    = err_ff;
    assign DATA_STALE_O    = stale_ff;

    // checks
    sequence s_direct_write;
        !mux_mode_ff && is_mrs;
    endsequence
    sequence s_mux_second;
        mux_mode_ff && apply;
    endsequence

    a_wl_rl_gap: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        WRITE_LAT_O == READ_LAT_O + 4'h1) else $error("write latency not read plus one");
    a_mux_adds_one: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        READ_LAT_O == trl_ff + {3'h0, MUX_MODE_O}) else $error("mux latency offset wrong");
    a_cfg_six: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        s_direct_write ##0 (addr[2:0] == CFG_2) |=> ROW_CYCLE_O == 4'h6 && READ_LAT_O == 4'h6)
        else $error("code two decode wrong");
    a_cfg_three: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        s_direct_write ##0 (addr[2:0] == CFG_4) |=> ROW_CYCLE_O == 4'h3) else $error("code four decode wrong");
    a_mux_entry: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        s_direct_write ##0 addr[MUX_BIT] |=> MUX_MODE_O) else $error("mux entry missed");
    a_mux_two_edges: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        s_mux_second |-> $past(second_pend_ff)) else $error("mux word applied without first part");
    a_dll_off: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        apply && !word[DLL_BIT] |=> !DLL_ON_O && !DLL_LOCKED_O) else $error("dll not turned off");
    a_stale_flag: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        apply && bl_decode(word[BL_LSB+1:BL_LSB]) != BURST_LEN_O |=> DATA_STALE_O)
        else $error("burst change not flagged");
    a_ready_gate: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        $rose(INIT_DONE_O) |-> $past(banks_ff) == ALL_BANKS && $past(nop_ff) == 11'(INIT_NOP_COUNT))
        else $error("ready before refresh and no-ops");
    a_recovery_load: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        is_mrs |=> rec_ff == 3'h5) else $error("recovery count not loaded");
    a_dll_default: assert property (@(posedge REF_CLK_I)
        $fell(RST_I) |-> !DLL_ON_O) else $error("dll on after reset");
endmodule
`default_nettype wire

/* File: dv/ctrl_model.sv */
// memory controller model driving the command, bank and address pins
`timescale 1ns/100ps
`default_nettype none
module ctrl_model
    import dram_mode_pkg::*;
(
    input  wire logic              ref_clk_i,
    output logic                   ck_o,
    output logic                   cs_n_o,
    output logic                   we_n_o,
    output logic                   ref_n_o,
    output logic [2:0]             bank_o,
    output logic [ADDR_W-1:0]      addr_o
);
    localparam logic [2:0] CMD_MRS  = 3'h0;
    localparam logic [2:0] CMD_BANK_REFRESH_CMD = 3'h2;
    localparam logic [2:0] CMD_NOP  = 3'h7;

    initial begin
        ck_o = 1'b0;
        {cs_n_o, we_n_o, ref_n_o} = CMD_NOP;
        bank_o = 3'h0;
        addr_o = 21'h000000;
    end

    // pins change on the ck fall, so they stand 200 ns either side of the rise
    task automatic cyc(input logic [2:0] cmd, input logic [2:0] bank, input logic [ADDR_W-1:0] addr);
        @(negedge ref_clk_i);
        ck_o = 1'b0;
        {cs_n_o, we_n_o, ref_n_o} = cmd;
        bank_o = bank;
        addr_o = addr;
        repeat (4) @(negedge ref_clk_i);
        ck_o = 1'b1;
        repeat (3) @(negedge ref_clk_i);
    endtask

    // don't-care pins flip every cycle so a stale level never looks driven
    task automatic nops(input int n);
        for (int i = 0; i < n; i++) begin
            cyc(CMD_NOP, ~bank_o, ~addr_o);
        end
    endtask

    task automatic mrs_now(input logic [ADDR_W-1:0] addr);
        cyc(CMD_MRS, ~bank_o, addr & 21'h0003ff);
    endtask

    task automatic mode_register_write_cmd(input logic [ADDR_W-1:0] addr);
        mrs_now(addr);
        nops(MODE_WRITE_RECOVERY_TIME);
    endtask

    task automatic refresh(input logic [2:0] bank);
        cyc(CMD_BANK_REFRESH_CMD, bank, ~addr_o);
    endtask

    task automatic mux_part(input logic [ADDR_W-1:0] ax, input logic [ADDR_W-1:0] ay);
        mrs_now(ax);
        cyc(CMD_NOP, ~bank_o, ay & 21'h0003ff);
    endtask

    task automatic mux_mrs(input logic [ADDR_W-1:0] ax, input logic [ADDR_W-1:0] ay);
        mux_part(ax, ay);
        nops(MODE_WRITE_RECOVERY_TIME);
    endtask
endmodule
`default_nettype wire

/* File: dv/test_dram_mode_setup.sv */
// testbench for the init and mode setup block
`timescale 1ns/100ps
`default_nettype none
module test_dram_mode_setup;
    import dram_mode_pkg::*;
    logic              ref_clk = 1'b0;
    logic              rst     = 1'b1;
    logic              ck, cs_n, we_n, ref_n;
    logic [2:0]        bank;
    logic [ADDR_W-1:0] addr;
    logic [MODE_W-1:0] mode_word;
    logic [3:0]        row_cycle_time, rl, wl, bl;
    logic [4:0]        top_bit;
    logic              mux, dll_on, dll_lock, imp, on_die_termination_enable, done, rsv, terr, stale;
    int                err_total = 0;
    int                checked   = 0;
    // cfg, burst code, row cycle, read latency
    logic [3:0]        tbl [6][4] = '{'{4'h0, 4'h0, 4'h4, 4'h4}, '{4'h1, 4'h1, 4'h4, 4'h4},
                                      '{4'h2, 4'h2, 4'h6, 4'h6}, '{4'h3, 4'h2, 4'h8, 4'h8},
                                      '{4'h4, 4'h1, 4'h3, 4'h3}, '{4'h5, 4'h0, 4'h5, 4'h5}};

    always #25 ref_clk = ~ref_clk;

    ctrl_model m (.ref_clk_i(ref_clk), .ck_o(ck), .cs_n_o(cs_n), .we_n_o(we_n), .ref_n_o(ref_n),
                  .bank_o(bank), .addr_o(addr));

    dram_mode_setup DUT (.REF_CLK_I(ref_clk), .RST_I(rst), .CK_I(ck), .CS_N_I(cs_n), .WE_N_I(we_n),
        .REF_N_I(ref_n), .BANK_SELECT_BITS_I(bank), .ADDR_I(addr), .MODE_WORD_O(mode_word),
        .ROW_CYCLE_O(row_cycle_time), .READ_LAT_O(rl), .WRITE_LAT_O(wl), .BURST_LEN_O(bl), .ADDR_TOP_BIT_O(top_bit),
        .MUX_MODE_O(mux), .DLL_ON_O(dll_on), .DLL_LOCKED_O(dll_lock), .IMPEDANCE_EXT_O(imp),
        .ODT_EN_O(on_die_termination_enable), .INIT_DONE_O(done), .CFG_RESERVED_O(rsv), .TIMING_ERR_O(terr),
        .DATA_STALE_O(stale));

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic chk_lat(input logic [3:0] t, input logic [3:0] r);
        chk("row_cycle", row_cycle_time, t);
        chk("read_lat", rl, r);
        chk("write_lat", wl, r + 4'h1);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // whole run is about 2700 link cycles of 8 clocks each
    initial begin
        repeat (60000) @(posedge ref_clk);
        err_total++;
        close_out();
    end

    initial begin
        repeat (4) @(negedge ref_clk);
        rst = 1'b0;
        chk_lat(4'h4, 4'h4);
        chk("burst", bl, 4'h2);
        chk("dll_on", dll_on, 1'b0);
        chk("mux", mux, 1'b0);
        chk("stale", stale, 1'b0);
        chk("done", done, 1'b0);
        m.nops(500);
        m.mrs_now(21'h000000);
        m.mrs_now(21'h000000);
        m.mrs_now(21'h00038a);
        m.nops(6);
        chk("mode_word", mode_word, 18'h0038a);
        chk_lat(4'h6, 4'h6);
        chk("burst", bl, 4'h4);
        chk("top_bit", top_bit, 5'h12);
        chk("imp", imp, 1'b1);
        chk("odt", on_die_termination_enable, 1'b1);
        chk("dll_lock", dll_lock, 1'b0);
        chk("terr", terr, 1'b0);
        for (int b = 0; b < 8; b++) begin
            m.refresh(b[2:0]);
        end
        m.nops(1000);
        chk("done", done, 1'b0);
        m.nops(25);
        chk("done", done, 1'b1);
        chk("dll_lock", dll_lock, 1'b1);
        for (int i = 0; i < 6; i++) begin
            m.mode_register_write_cmd({13'h0000, 1'b1, 2'h0, tbl[i][1][1:0], tbl[i][0][2:0]});
            chk_lat(tbl[i][2], tbl[i][3]);
            chk("burst", bl, 4'h2 << tbl[i][1]);
            chk("top_bit", top_bit, 5'h13 - tbl[i][1]);
            chk("rsv", rsv, 1'b0);
        end
        chk("stale", stale, 1'b1);
        chk("imp", imp, 1'b0);
        chk("odt", on_die_termination_enable, 1'b0);
        m.mode_register_write_cmd(21'h000086);
        chk_lat(4'h5, 4'h5);
        chk("rsv", rsv, 1'b1);
        m.mode_register_write_cmd(21'h000087);
        chk("rsv", rsv, 1'b1);
        m.mode_register_write_cmd(21'h000000);
        chk("dll_on", dll_on, 1'b0);
        chk("dll_lock", dll_lock, 1'b0);
        m.mode_register_write_cmd(21'h000080);
        chk("dll_lock", dll_lock, 1'b0);
        m.nops(1030);
        chk("dll_lock", dll_lock, 1'b1);
        m.mode_register_write_cmd(21'h000020);
        chk("mux", mux, 1'b1);
        chk_lat(4'h4, 4'h5);
        m.mux_mrs(21'h000001, 21'h000018);
        chk_lat(4'h4, 4'h5);
        m.mux_mrs(21'h000021, 21'h000088);
        chk_lat(4'h8, 4'h9);
        chk("dll_on", dll_on, 1'b1);
        chk("mode_word", mode_word, 18'h000a3);
        chk("terr", terr, 1'b0);
        m.mux_part(21'h000021, 21'h000000);
        m.refresh(3'h2);
        m.nops(2);
        chk("terr", terr, 1'b1);
        // mid-run reset: sticky flags and settings must clear
        rst = 1'b1;
        repeat (4) @(negedge ref_clk);
        rst = 1'b0;
        chk("terr", terr, 1'b0);
        chk("stale", stale, 1'b0);
        chk("mux", mux, 1'b0);
        chk("done", done, 1'b0);
        chk("dll_on", dll_on, 1'b0);
        chk_lat(4'h4, 4'h4);
        close_out();
    end
endmodule
`default_nettype wire
